//--- verilog/bemf_zc_map.vh
`ifndef BEMF_ZC_MAP_VH
`define BEMF_ZC_MAP_VH
// =====================================================================
// Field widths and reset values
`define BZC_TIMER_W        16
`define BZC_CNT_W          4
`define BZC_CNT_RST        4'h0
`define BZC_OS_W           3
`define BZC_TIMER_RST      16'h0000
// =====================================================================
// Step phase codes
`define BZC_PH_IDLE        2'h0
`define BZC_PH_DEMAG       2'h1
`define BZC_PH_ZC          2'h2
`define BZC_PH_DONE        2'h3
`endif

//--- verilog/bzc_events.v
// Operation
// RL1: Hardware demag event is an edge on selected phase input, polarity from edge/level bits.
// RL2: Hardware demag needs programmable count of consecutive sampled detections.
// RL3: With hardware demag capture on, timer is copied into demag time register.
// RL4: With simulated demag on, timer match with demag time register raises event.
// RL5: With both demag modes on, first of the two is the step's event.
// RL6: Software keeps simulated-only masking time longer than real demagnetization.
// RL7: Any demag event sets demag flag; interrupt requested when its mask set.
// RL8: After commutation, demag register at or below timer fires now and takes timer.
// RL9: Zero-cross sampling starts only after commutation and demag; output group may switch.
// RL10: After zero cross, PWM may switch to a further group before next commutation.
// RL11: Hardware zero cross needs programmable count of consecutive sampled detections.
// RL12: Back-EMF is read only while PWM sits on the sensing group.
// RL13: With hardware zero-cross capture on, timer is copied into zero-cross register.
// RL14: With simulated zero cross on, timer match with zero-cross register raises event.
// RL15: With both zero-cross modes on, first of the two is accepted.
// RL16: Qualified zero cross sets its flag; interrupt requested when its mask set.
// RL17: After demag, zero-cross register at or below timer fires now and takes timer.
// RL18: Without edge protection, current sample at expected level raises zero cross.
// RL19: With edge protection, previous sample must hold the opposite level.
// RL20: No edge protection in Hall mode or for simulated zero crossings.
// RL21: With edge protection, the consecutive-count filter setting is ignored.
// RL22: Count field encodes limit as value plus one, 1 to 16, 1 after reset.
// RL23: Count filter acts on hardware zero crossings only; simulated count is one.
// RL24: Each simulated comparison fires at most once per step, first equal cycle.
`timescale 1ns/10ps
`include "bemf_zc_map.vh"

module bzc_events #(
    parameter TW = `BZC_TIMER_W,
    parameter CW = `BZC_CNT_W
) (
    input  wire          mclk,
    input  wire          sys_rst,
    input  wire          phase_sense_input,
    input  wire          sample_strobe,
    input  wire          pwm_on_sense_group,
    input  wire          sense_group_select,
    input  wire          commutation_event,
    input  wire [TW-1:0] motor_step_timer,
    input  wire          hw_demag_capture_en,
    input  wire          sim_demag_en,
    input  wire          hw_zero_cross_capture_en,
    input  wire          sim_zero_cross_en,
    input  wire          hall_sensor_mode,
    input  wire          zero_cross_edge_protect,
    input  wire          edge_direction_sel,
    input  wire          comparator_edge_polarity,
    input  wire [CW-1:0] demag_count_limit,
    input  wire [CW-1:0] zero_cross_count_limit,
    input  wire [2:0]    output_switch_sel,
    input  wire          demag_irq_mask,
    input  wire          zero_cross_irq_mask,
    input  wire          demag_flag_clear,
    input  wire          zero_cross_flag_clear,
    input  wire          demag_time_wr,
    input  wire          zero_cross_time_wr,
    input  wire [TW-1:0] time_wr_data,
    output reg  [TW-1:0] demag_time_reg,
    output reg  [TW-1:0] zero_cross_time_reg,
    output reg           demag_irq_flag,
    output reg           zero_cross_irq_flag,
    output wire          demag_irq_req,
    output wire          zero_cross_irq_req,
    output reg           demag_event,
    output reg           zero_cross_event,
    output reg  [1:0]    pwm_group_sel,
    output reg  [1:0]    step_phase,
    output reg           comp_sample
);

    // =================================================================
    // Input synchronisers
    reg  [1:0] sense_sync;
    reg  [1:0] strobe_sync;
    reg        strobe_prev;
    reg        prev_sample;
    wire       sample_tick = strobe_sync[1] & ~strobe_prev;

    always @(posedge mclk) begin
        if (sys_rst) begin
            sense_sync  <= 2'b00;
            strobe_sync <= 2'b00;
            strobe_prev <= 1'b0;
        end else begin
            sense_sync  <= {sense_sync[0], phase_sense_input};
            strobe_sync <= {strobe_sync[0], sample_strobe};
            strobe_prev <= strobe_sync[1];
        end
    end

    // =================================================================
    // Expected comparator level after an event of each kind.
    // Demag and zero cross normally see opposite edges unless the
    // direction bit makes them alike.
    wire demag_level = edge_direction_sel ? comparator_edge_polarity
                                          : ~comparator_edge_polarity;
    wire zc_level    = comparator_edge_polarity;

    // =================================================================
    // Shared decodes
    // Comparator sample against the level that an event expects
    function bzc_at_level;
        input sample;
        input level;
        begin
            bzc_at_level = (sample == level);
        end
    endfunction

    // A stored time at or below the timer is already due
    function bzc_due;
        input [TW-1:0] stored;
        input [TW-1:0] timer;
        begin
            bzc_due = (stored <= timer);
        end
    endfunction

    // One step of a consecutive-detection filter; a miss restarts it and
    // the count saturates at the limit so a long level cannot wrap it
    function [CW-1:0] bzc_next_cnt;
        input          hit;
        input [CW-1:0] cnt;
        input [CW-1:0] limit;
        begin
            if (!hit)
                bzc_next_cnt = `BZC_CNT_RST;
            else if (cnt != limit)
                bzc_next_cnt = cnt + 1'b1;
            else
                bzc_next_cnt = cnt;
        end
    endfunction

    // =================================================================
    // Step sequencing
    wire in_demag = (step_phase == `BZC_PH_DEMAG);
    wire in_zc    = (step_phase == `BZC_PH_ZC);
    reg  demag_chk;
    reg  zc_chk;
    reg  [CW-1:0] demag_cnt;
    reg  [CW-1:0] zc_cnt;

    // Demagnetization hardware detection, sampled at the sample tick
    wire demag_hit   = sample_tick & bzc_at_level(sense_sync[1], demag_level); // [RL1]
    wire demag_hw    = in_demag & ~hall_sensor_mode & demag_hit &
                       (demag_cnt == demag_count_limit);                   // [RL2]
    // Simulated demag: match only inside the phase, so once per step
    wire demag_match = in_demag & ~demag_chk & sim_demag_en &
                       (motor_step_timer == demag_time_reg);               // [RL4] [RL24]
    wire demag_late  = in_demag & demag_chk & sim_demag_en &
                       bzc_due(demag_time_reg, motor_step_timer);          // [RL8]
    wire demag_sim   = demag_match | demag_late;
    wire demag_any   = in_demag & (demag_hw | demag_sim);                  // [RL5]

    // Zero-cross hardware detection only while PWM on the sense group, or at any time in Hall mode
    wire zc_window   = in_zc & (hall_sensor_mode |
                       (pwm_on_sense_group == sense_group_select));        // [RL12]
    wire zc_lvl_ok   = sample_tick & bzc_at_level(sense_sync[1], zc_level); // [RL18]
    wire protect_on  = zero_cross_edge_protect & ~hall_sensor_mode;        // [RL20]
    wire zc_edge_ok  = zc_lvl_ok & (prev_sample != sense_sync[1]);         // [RL19]
    wire zc_hw       = zc_window & (protect_on ? zc_edge_ok :              // [RL21]
                       (zc_lvl_ok & (zc_cnt == zero_cross_count_limit)));  // [RL11] [RL22]
    wire zc_match    = in_zc & ~zc_chk & sim_zero_cross_en &
                       (motor_step_timer == zero_cross_time_reg);          // [RL14] [RL24]
    wire zc_late     = in_zc & zc_chk & sim_zero_cross_en &
                       bzc_due(zero_cross_time_reg, motor_step_timer);     // [RL17]
    // Simulated zero cross bypasses filter and protection
    wire zc_sim      = zc_match | zc_late;                                 // [RL23]
    wire zc_any      = zc_hw | zc_sim;                                     // [RL15]

    always @(posedge mclk) begin
        if (sys_rst) begin
            step_phase  <= `BZC_PH_IDLE;
            demag_chk   <= 1'b0;
            zc_chk      <= 1'b0;
            prev_sample <= 1'b0;
            comp_sample <= 1'b0;
        end else begin
            demag_chk <= 1'b0;
            zc_chk    <= 1'b0;
            if (sample_tick) begin
                prev_sample <= sense_sync[1];
                comp_sample <= sense_sync[1];
            end
            if (commutation_event) begin
                // A new commutation always starts a fresh step
                step_phase <= hall_sensor_mode ? `BZC_PH_ZC : `BZC_PH_DEMAG;
                demag_chk  <= ~hall_sensor_mode;                           // [RL8]
                zc_chk     <= hall_sensor_mode;
            end else begin
                case (step_phase)
                    `BZC_PH_DEMAG: begin
                        if (demag_any) begin
                            step_phase <= `BZC_PH_ZC;                      // [RL9]
                            zc_chk     <= 1'b1;                            // [RL17]
                        end
                    end
                    `BZC_PH_ZC: begin
                        if (zc_any)
                            step_phase <= `BZC_PH_DONE;
                    end
                    `BZC_PH_DONE: begin
                        step_phase <= `BZC_PH_DONE;
                    end
                    default: begin
                        step_phase <= `BZC_PH_IDLE;
                    end
                endcase
            end
        end
    end

    // =================================================================
    // Filter counters. Kept apart from the step sequencer so that each
    // counter has a single next value; commutation restarts both and a finished
    // demag restarts the zero-cross one, so stale matches from the last step never
    // shorten the filter of the next one.
    reg  [CW-1:0] next_demag_cnt;
    reg  [CW-1:0] next_zc_cnt;

    always @* begin
        next_demag_cnt = demag_cnt;
        next_zc_cnt    = zc_cnt;
        if (sample_tick && in_demag)
            next_demag_cnt = bzc_next_cnt(bzc_at_level(sense_sync[1], demag_level),
                                          demag_cnt, demag_count_limit);    // [RL2]
        if (sample_tick && zc_window)
            next_zc_cnt = bzc_next_cnt(bzc_at_level(sense_sync[1], zc_level),
                                       zc_cnt, zero_cross_count_limit);     // [RL11]
        if (commutation_event) begin
            next_demag_cnt = `BZC_CNT_RST;
            next_zc_cnt    = `BZC_CNT_RST;
        end else if (demag_any) begin
            next_zc_cnt    = `BZC_CNT_RST;
        end
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            demag_cnt <= `BZC_CNT_RST;
            zc_cnt    <= `BZC_CNT_RST;
        end else begin
            demag_cnt <= next_demag_cnt;
            zc_cnt    <= next_zc_cnt;
        end
    end

    // =================================================================
    // Time registers: software write, capture, and late-compare overwrite.
    // Hardware capture wins over a same-cycle software write.
    always @(posedge mclk) begin
        if (sys_rst) begin
            demag_time_reg      <= `BZC_TIMER_RST;
            zero_cross_time_reg <= `BZC_TIMER_RST;
        end else begin
            if (demag_any && demag_hw && !demag_sim && hw_demag_capture_en)
                demag_time_reg <= motor_step_timer;                        // [RL3]
            else if (demag_late)
                demag_time_reg <= motor_step_timer;                        // [RL8]
            else if (demag_time_wr)
                demag_time_reg <= time_wr_data;
            if (zc_hw && !zc_sim && hw_zero_cross_capture_en)
                zero_cross_time_reg <= motor_step_timer;                   // [RL13]
            else if (zc_late)
                zero_cross_time_reg <= motor_step_timer;                   // [RL17]
            else if (zero_cross_time_wr)
                zero_cross_time_reg <= time_wr_data;
        end
    end

    // =================================================================
    // Flags, events and output-group selection
    always @(posedge mclk) begin
        if (sys_rst) begin
            demag_irq_flag      <= 1'b0;
            zero_cross_irq_flag <= 1'b0;
            demag_event         <= 1'b0;
            zero_cross_event    <= 1'b0;
            pwm_group_sel       <= 2'b00;
        end else begin
            demag_event      <= demag_any;
            zero_cross_event <= zc_any;
            // Set beats a clear arriving in the same cycle
            if (demag_any)
                demag_irq_flag <= 1'b1;                                    // [RL7]
            else if (demag_flag_clear)
                demag_irq_flag <= 1'b0;
            if (zc_any)
                zero_cross_irq_flag <= 1'b1;                               // [RL16]
            else if (zero_cross_flag_clear)
                zero_cross_irq_flag <= 1'b0;
            if (commutation_event)
                pwm_group_sel <= 2'b00;
            else if (demag_any && output_switch_sel[0])
                pwm_group_sel <= 2'b01;                                    // [RL9]
            else if (zc_any && output_switch_sel[1])
                pwm_group_sel <= 2'b10;                                    // [RL10]
        end
    end

    assign demag_irq_req      = demag_irq_flag & demag_irq_mask;           // [RL7]
    assign zero_cross_irq_req = zero_cross_irq_flag & zero_cross_irq_mask; // [RL16]

endmodule

//--- tb/bzc_checker.sv
`timescale 1ns/10ps
// ==========================================================
// Port checks on demag and zero-cross events
module bzc_checker #(
    parameter TW = 16
) (
    input wire          mclk,
    input wire          sys_rst,
    input wire          commutation_event,
    input wire          hall_sensor_mode,
    input wire          sim_demag_en,
    input wire          sim_zero_cross_en,
    input wire          demag_irq_mask,
    input wire [TW-1:0] motor_step_timer,
    input wire [TW-1:0] demag_time_reg,
    input wire [TW-1:0] zero_cross_time_reg,
    input wire          demag_irq_flag,
    input wire          zero_cross_irq_flag,
    input wire          demag_irq_req,
    input wire          demag_event,
    input wire          zero_cross_event,
    input wire [1:0]    step_phase
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_dm_late;
        commutation_event && sim_demag_en && !hall_sensor_mode
        ##1 !commutation_event && sim_demag_en && demag_time_reg <= motor_step_timer;
    endsequence
    sequence s_zc_late;
        demag_event && sim_zero_cross_en && !commutation_event
        && zero_cross_time_reg <= motor_step_timer;
    endsequence
    property p_dm_late;
        s_dm_late |=> demag_event && demag_time_reg == $past(motor_step_timer);
    endproperty
    property p_zc_late; s_zc_late |=> zero_cross_event; endproperty
    property p_dm_match;
        step_phase == 2'h1 && sim_demag_en && !commutation_event
        && motor_step_timer == demag_time_reg |=> demag_event;
    endproperty
    property p_zc_match;
        step_phase == 2'h2 && sim_zero_cross_en && !commutation_event
        && motor_step_timer == zero_cross_time_reg |=> zero_cross_event;
    endproperty
    property p_commute; commutation_event && !hall_sensor_mode |=> step_phase == 2'h1; endproperty
    property p_zc_phase; zero_cross_event |-> $past(step_phase) == 2'h2; endproperty
    property p_dm_once; demag_event |=> !demag_event; endproperty
    property p_dm_flag; demag_event |-> demag_irq_flag; endproperty
    property p_zc_flag; zero_cross_event |-> zero_cross_irq_flag; endproperty
    property p_dm_req; demag_irq_req == (demag_irq_flag && demag_irq_mask); endproperty
    a_dm_late: assert property (p_dm_late) else $error("late demag check missed");
    a_zc_late: assert property (p_zc_late) else $error("late zc check missed");
    a_dm_match: assert property (p_dm_match) else $error("demag match missed");
    a_zc_match: assert property (p_zc_match) else $error("zc match missed");
    a_commute: assert property (p_commute) else $error("step did not start");
    a_zc_phase: assert property (p_zc_phase) else $error("zc outside its phase");
    a_dm_once: assert property (p_dm_once) else $error("demag fired twice");
    a_dm_flag: assert property (p_dm_flag) else $error("demag flag not set");
    a_zc_flag: assert property (p_zc_flag) else $error("zc flag not set");
    a_dm_req: assert property (p_dm_req) else $error("demag request wrong");
endmodule

//--- tb/bzc_comp_model.sv
`timescale 1ns/10ps
// ==========================================================
// Phase comparator and free-running sample clock
module bzc_comp_model (
    input  wire  mclk,
    input  wire  level,
    output logic phase_sense_input = 1'b0,
    output logic sample_strobe = 1'b0
);
    logic [1:0] div = 2'h0;
    // Ticks every four cycles, slower than the sync delay, so no tick is lost
    always @(posedge mclk) begin
        div <= div + 2'h1;
        sample_strobe <= div[1];
        phase_sense_input <= level;
    end
endmodule

//--- tb/bzc_events_bench.sv
`timescale 1ns/10ps
module bzc_events_bench;
    typedef struct {logic sd, sz; logic [15:0] dr, zr, t; logic ed, ez;} bzc_row_t;
    logic        mclk, sys_rst, com, lvl, pwm, sgs, sd, sz, hd, hz, pe, ramp, ps;
    logic        dm, zm, dclr, zclr, dwr, zwr, hall;
    logic [2:0]  osw;
    wire  [1:0]  grp;
    wire         csmp;
    logic [3:0]  zlim;
    logic [15:0] wd, tmr;
    wire  [15:0] demag_time_reg, zero_cross_time_reg;
    wire         demag_irq_flag, zero_cross_irq_flag, demag_irq_req, zero_cross_irq_req;
    wire         demag_event, zero_cross_event, phase_sense_input, sample_strobe;
    wire  [1:0]  step_phase;
    int          num_errors = 0, checks_done = 0, ndm, nzc, nt, tz;
    bzc_row_t    rows [4] = '{
        '{1'b1, 1'b1, 16'h0010, 16'h0010, 16'h0020, 1'b1, 1'b1}, // Simulated only
        '{1'b1, 1'b1, 16'h0020, 16'h0021, 16'h0020, 1'b1, 1'b0},
        '{1'b1, 1'b0, 16'h0030, 16'h0000, 16'h0020, 1'b0, 1'b0},
        '{1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0020, 1'b0, 1'b0}};
    bzc_comp_model u_bzc_comp_model (.mclk, .level(lvl), .phase_sense_input, .sample_strobe);
    bzc_events u_bzc_events (
        .mclk, .sys_rst, .phase_sense_input, .sample_strobe,
        .pwm_on_sense_group(pwm), .sense_group_select(sgs), .commutation_event(com),
        .motor_step_timer(tmr), .hw_demag_capture_en(hd), .sim_demag_en(sd),
        .hw_zero_cross_capture_en(hz), .sim_zero_cross_en(sz), .hall_sensor_mode(hall),
        .zero_cross_edge_protect(pe), .edge_direction_sel(1'b0),
        .comparator_edge_polarity(1'b0), .demag_count_limit(4'h0),
        .zero_cross_count_limit(zlim), .output_switch_sel(osw), .demag_irq_mask(dm),
        .zero_cross_irq_mask(zm), .demag_flag_clear(dclr), .zero_cross_flag_clear(zclr),
        .demag_time_wr(dwr), .zero_cross_time_wr(zwr), .time_wr_data(wd),
        .demag_time_reg, .zero_cross_time_reg, .demag_irq_flag, .zero_cross_irq_flag,
        .demag_irq_req, .zero_cross_irq_req, .demag_event, .zero_cross_event,
        .pwm_group_sel(grp), .step_phase, .comp_sample(csmp));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task chk(input logic [15:0] e, input logic [15:0] s, input string n);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %0s expected %h seen %h", n, e, s);
        end
    endtask
    // Loads both time registers, then starts a step; returns in its second cycle
    task step(input logic [15:0] dr, input logic [15:0] zr, input logic [15:0] t);
        dwr = 1'b1; wd = dr; tmr = t; tick(1);
        dwr = 1'b0; zwr = 1'b1; wd = zr; tick(1);
        zwr = 1'b0; com = 1'b1; tick(1);
        com = 1'b0; tick(1);
    endtask
    task watch(input int n);
        ndm = 0; nzc = 0; nt = 0; tz = 99;
        repeat (n) begin
            tick(1);
            if (sample_strobe && !ps) nt++;
            ps = sample_strobe;
            if (demag_event === 1'b1) ndm++;
            if (zero_cross_event === 1'b1) begin
                if (nzc == 0) tz = nt;
                nzc++;
            end
            if (ramp) tmr = tmr + 16'h0001;
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        $display("BAD watchdog expected end seen hang");
        finish_test;
    end
    // ==========================================================
    // Main sequence
    initial begin
        {sys_rst, com, lvl, pwm, sd, sz, hd, hz, pe, ramp, ps} = 11'h400;
        {dm, zm, dclr, zclr, dwr, zwr, sgs, zlim, wd, tmr} = 43'h002_0000_0000;
        osw = 3'h1; hall = 1'b0;
        tick(4);
        sys_rst = 1'b0;
        chk(16'h0000, {step_phase, demag_irq_flag, zero_cross_irq_flag}, "rst_state");
        chk(16'h0000, demag_time_reg | zero_cross_time_reg, "rst_regs");
        foreach (rows[i]) begin
            sd = rows[i].sd; sz = rows[i].sz;
            step(rows[i].dr, rows[i].zr, rows[i].t);
            chk(rows[i].ed, demag_event, "dm_event");
            chk(rows[i].ed ? rows[i].t : rows[i].dr, demag_time_reg, "dm_reg");
            chk(rows[i].ed, grp, "grp_demag");
            tick(1);
            chk(rows[i].ez, zero_cross_event, "zc_event");
        end
        $display("test rows finished");
        sd = 1'b1; sz = 1'b0; hd = 1'b1; hz = 1'b1; pwm = 1'b1; zlim = 4'h3; lvl = 1'b1;
        step(16'h0000, 16'hffff, 16'h0123);
        sgs = 1'b0; lvl = 1'b0; watch(30);
        chk(0, nzc, "zc_off_group");
        lvl = 1'b1; watch(12);
        sgs = 1'b1; lvl = 1'b0; watch(60);
        chk(1, nzc, "zc_hw");
        chk(1, tz >= 4, "zc_ticks");
        chk(16'h0123, zero_cross_time_reg, "zc_capture");
        $display("test hw_zero_cross finished");
        pe = 1'b1; hz = 1'b0;
        step(16'h0000, 16'hffff, 16'h0200);
        watch(30);
        chk(0, nzc, "zc_no_edge");
        lvl = 1'b1; watch(12);
        chk(1, csmp, "comp_sample");
        lvl = 1'b0; watch(30);
        chk(1, nzc, "zc_edge");
        chk(1, tz <= 2, "zc_no_count");
        $display("test edge_protect finished");
        pe = 1'b0; hd = 1'b0; sz = 1'b1; sgs = 1'b0; ramp = 1'b1; osw = 3'h3;
        step(16'h0050, 16'h0060, 16'h0040);
        watch(60);
        chk(1, ndm, "dm_match");
        chk(1, nzc, "zc_match");
        chk(2, grp, "grp_zc");
        $display("test match finished");
        dm = 1'b1; zm = 1'b1; tick(1);
        chk(1, {demag_irq_req, zero_cross_irq_req} == 2'h3, "irq_req");
        dclr = 1'b1; zclr = 1'b1; tick(1);
        dclr = 1'b0; zclr = 1'b0;
        chk(0, {demag_irq_flag, zero_cross_irq_req}, "irq_clear");
        $display("test flags finished");
        hall = 1'b1; pe = 1'b1; sd = 1'b1; sz = 1'b0; ramp = 1'b0; lvl = 1'b0;
        step(16'h0000, 16'hffff, 16'h0300);
        watch(40);
        chk(1, nzc, "zc_hall");
        chk(0, ndm, "dm_hall");
        $display("test hall finished");
        finish_test;
    end
endmodule
bind bzc_events bzc_checker #(.TW(TW)) u_bzc_checker (
    .mclk, .sys_rst, .commutation_event, .hall_sensor_mode, .sim_demag_en,
    .sim_zero_cross_en, .demag_irq_mask, .motor_step_timer, .demag_time_reg,
    .zero_cross_time_reg, .demag_irq_flag, .zero_cross_irq_flag, .demag_irq_req,
    .demag_event, .zero_cross_event, .step_phase);
